// [rtl/serial_rx_status_flags.v]
`timescale 1ns/10ps
`include "serial_rx_status_flags_defs.vh"

// Functional notes
// - Stop bit zero sets framing error
// - Unread buffer zero sets overrun, still overwrites
// - Parity mismatch sets parity error bit 2
// - Address marker while data expected sets bit 3
// - Bit 4 gates receive-ready request
// - Receive-ready bit 5 sticky until software clears
// - Bit 6 gates transmit-ready request
// - Transmit-ready bit 7 sticky until software clears
// - Buffer one/two errors update second status
// - Error flags stay set until cleared
// - Unread buffers one, two re-set overrun
// - Overrun flags one/two set, byte stored
// - Parity flags one/two on mismatch
// - Address-error flags one/two on marker
// - Buffer three errors update third status
// - Unread buffer three re-sets overrun
// - Index bits read-only, show next buffer
// - Reset second 11H, third C1H
// - Unimplemented status bits read one
// - Index encodes buffers zero to three
// - Four-stage mode stores in ring order
// - One framing flag serves all buffers
// - Primary status resets to 00H
module serial_rx_status_flags (
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire rx_done,
	input wire [7:0] rx_data,
	input wire rx_parity_bit,
	input wire rx_stop_bit,
	input wire address_marker_bit,
	input wire tx_ready_event,
	output reg rx_ready_irq,
	output reg tx_ready_irq
);

	// ==========================================================
	// State
	reg [7:0] buf_mem [0:3];
	reg [3:0] unread_ff;
	reg [3:0] overrun_ff;
	reg [3:0] parity_ff;
	reg [3:0] addr_err_ff;
	reg framing_error_flag_ff;
	reg rx_ready_irq_enable_ff;
	reg rx_ready_request_ff;
	reg tx_ready_irq_enable_ff;
	reg tx_ready_request_ff;
	reg [1:0] next_index_ff;
	reg [7:0] rx_control_register_ff;
	reg bus_wait_ff;

	// ==========================================================
	// Control decode
	wire mp_mode;
	wire rx_expect_address;
	wire four_stage_buffer_select;
	wire parity_en;
	wire parity_even;
	assign mp_mode = rx_control_register_ff[`BIT_CTL_MP_MODE];
	assign rx_expect_address = rx_control_register_ff[`BIT_CTL_EXPECT_ADDR];
	assign four_stage_buffer_select =
		rx_control_register_ff[`BIT_CTL_FOUR_STAGE];
	assign parity_en = rx_control_register_ff[`BIT_CTL_PARITY_EN];
	assign parity_even = rx_control_register_ff[`BIT_CTL_PARITY_EVEN];

	// ==========================================================
	// Reception evaluation
	// Frames without address marker are dropped while waiting for one
	wire rx_ignored;
	wire rx_store;
	wire [1:0] target;
	wire expected_parity;
	wire parity_bad;
	wire addr_bad;
	assign rx_ignored = mp_mode & rx_expect_address & ~address_marker_bit;
	assign rx_store = rx_done & ~rx_ignored;
	assign target = four_stage_buffer_select ? next_index_ff : 2'h0;
	assign expected_parity = parity_even ? (^rx_data) : ~(^rx_data);
	assign parity_bad = parity_en & (expected_parity != rx_parity_bit);
	assign addr_bad = mp_mode & ~rx_expect_address & address_marker_bit;

	// ==========================================================
	// Bus access decode
	// Access completes on the edge where waitrequest is seen low
	wire bus_take;
	wire wr_take;
	wire rd_take;
	wire wr_lane;
	assign bus_take = (avs_read | avs_write) & ~bus_wait_ff;
	assign wr_take = avs_write & ~bus_wait_ff;
	assign rd_take = avs_read & ~bus_wait_ff;
	assign wr_lane = avs_byteenable[0];
	wire [7:0] wbyte;
	assign wbyte = avs_writedata[7:0];

	// Clear masks: a written zero clears, a written one keeps
	reg [3:0] clr_overrun;
	reg [3:0] clr_parity;
	reg [3:0] clr_addr;
	reg clr_framing;
	reg clr_rx_req;
	reg clr_tx_req;
	reg [3:0] buf_read;
	always @* begin
		clr_overrun = 4'h0;
		clr_parity = 4'h0;
		clr_addr = 4'h0;
		clr_framing = 1'b0;
		clr_rx_req = 1'b0;
		clr_tx_req = 1'b0;
		buf_read = 4'h0;
		if (wr_take && wr_lane) begin
			case (avs_address)
				`OFS_RX_TX_STATUS_FLAGS: begin
					clr_framing = ~wbyte[`BIT_FRAMING_ERR];
					clr_overrun[0] = ~wbyte[`BIT_OVERRUN_ZERO];
					clr_parity[0] = ~wbyte[`BIT_PARITY_ZERO];
					clr_addr[0] = ~wbyte[`BIT_ADDR_ERR_ZERO];
					clr_rx_req = ~wbyte[`BIT_RX_REQ];
					clr_tx_req = ~wbyte[`BIT_TX_REQ];
				end
				`OFS_RX_STATUS_BUF_ONE_TWO: begin
					clr_overrun[1] = ~wbyte[`BIT_OVERRUN_ONE];
					clr_parity[1] = ~wbyte[`BIT_PARITY_ONE];
					clr_addr[1] = ~wbyte[`BIT_ADDR_ERR_ONE];
					clr_overrun[2] = ~wbyte[`BIT_OVERRUN_TWO];
					clr_parity[2] = ~wbyte[`BIT_PARITY_TWO];
					clr_addr[2] = ~wbyte[`BIT_ADDR_ERR_TWO];
				end
				`OFS_RX_STATUS_BUF_THREE_CNT: begin
					clr_overrun[3] = ~wbyte[`BIT_OVERRUN_THREE];
					clr_parity[3] = ~wbyte[`BIT_PARITY_THREE];
					clr_addr[3] = ~wbyte[`BIT_ADDR_ERR_THREE];
				end
				default: begin
					clr_framing = 1'b0;
				end
			endcase
		end
		if (rd_take) begin
			case (avs_address)
				`OFS_RX_BUFFER_ZERO: buf_read[0] = 1'b1;
				`OFS_RX_BUFFER_ONE: buf_read[1] = 1'b1;
				`OFS_RX_BUFFER_TWO: buf_read[2] = 1'b1;
				`OFS_RX_BUFFER_THREE: buf_read[3] = 1'b1;
				default: buf_read = 4'h0;
			endcase
		end
	end

	// Per-buffer set events of the byte being stored
	reg [3:0] hit;
	always @* begin
		hit = 4'h0;
		if (rx_store) begin
			hit[target] = 1'b1;
		end
	end

	// ==========================================================
	// Read mux
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = 8'h00;
		case (avs_address)
			`OFS_RX_TX_STATUS_FLAGS: begin
				rd_byte = {tx_ready_request_ff, tx_ready_irq_enable_ff,
					rx_ready_request_ff, rx_ready_irq_enable_ff,
					addr_err_ff[0], parity_ff[0], overrun_ff[0],
					framing_error_flag_ff};
			end
			`OFS_RX_STATUS_BUF_ONE_TWO: begin
				rd_byte = {addr_err_ff[2], parity_ff[2], overrun_ff[2], 1'b0,
					addr_err_ff[1], parity_ff[1], overrun_ff[1], 1'b0}
					| `ONES_BUF_ONE_TWO;
			end
			`OFS_RX_STATUS_BUF_THREE_CNT: begin
				rd_byte = {2'h0, next_index_ff, addr_err_ff[3], parity_ff[3],
					overrun_ff[3], 1'b0} | `ONES_BUF_THREE_CNT;
			end
			`OFS_RX_CONTROL: rd_byte = rx_control_register_ff;
			`OFS_RX_BUFFER_ZERO: rd_byte = buf_mem[0];
			`OFS_RX_BUFFER_ONE: rd_byte = buf_mem[1];
			`OFS_RX_BUFFER_TWO: rd_byte = buf_mem[2];
			`OFS_RX_BUFFER_THREE: rd_byte = buf_mem[3];
			default: rd_byte = 8'h00;
		endcase
	end

	// ==========================================================
	// Bus handshake: one wait cycle, then a single-cycle answer
	always @(posedge clock) begin
		if (sys_rst) begin
			bus_wait_ff <= 1'b1;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (bus_take) begin
				bus_wait_ff <= 1'b1;
				avs_waitrequest <= 1'b1;
			end else if (avs_read || avs_write) begin
				bus_wait_ff <= 1'b0;
				avs_waitrequest <= 1'b0;
				avs_readdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ==========================================================
	// Buffers and read tracking
	// Overwrite happens even on overrun; unread stays until the CPU reads
	// Each process owns its own loop index, so none has two drivers
	integer i;
	integer io;
	integer ip;
	integer ia;
	always @(posedge clock) begin
		if (sys_rst) begin
			unread_ff <= 4'h0;
			next_index_ff <= 2'h0;
		end else if (clk_en) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (hit[i]) begin
					buf_mem[i] <= rx_data;
					unread_ff[i] <= 1'b1;
				end else if (buf_read[i]) begin
					unread_ff[i] <= 1'b0;
				end
			end
			if (!four_stage_buffer_select) begin
				next_index_ff <= 2'h0;
			end else if (rx_store) begin
				next_index_ff <= next_index_ff + 2'h1;
			end
		end
	end

	// ==========================================================
	// Sticky error flags, set wins over clear
	// Overrun re-asserts whenever the previous byte was never read
	always @(posedge clock) begin
		if (sys_rst) begin
			overrun_ff <= 4'h0;
		end else if (clk_en) begin
			for (io = 0; io < 4; io = io + 1) begin
				if (hit[io] && unread_ff[io]) begin
					overrun_ff[io] <= 1'b1;
				end else if (clr_overrun[io]) begin
					overrun_ff[io] <= 1'b0;
				end
			end
		end
	end

	// Parity flags land on the buffer that took the byte
	always @(posedge clock) begin
		if (sys_rst) begin
			parity_ff <= 4'h0;
		end else if (clk_en) begin
			for (ip = 0; ip < 4; ip = ip + 1) begin
				if (hit[ip] && parity_bad) begin
					parity_ff[ip] <= 1'b1;
				end else if (clr_parity[ip]) begin
					parity_ff[ip] <= 1'b0;
				end
			end
		end
	end

	// Address-marker flags; addr_bad is zero outside multiprocessor mode
	always @(posedge clock) begin
		if (sys_rst) begin
			addr_err_ff <= 4'h0;
		end else if (clk_en) begin
			for (ia = 0; ia < 4; ia = ia + 1) begin
				if (hit[ia] && addr_bad) begin
					addr_err_ff[ia] <= 1'b1;
				end else if (clr_addr[ia]) begin
					addr_err_ff[ia] <= 1'b0;
				end
			end
		end
	end

	// One framing flag for all buffers, so a bad stop bit in any stored (not ignored) frame sets it
	// Software cannot tell which buffer held the bad frame
	always @(posedge clock) begin
		if (sys_rst) begin
			framing_error_flag_ff <= 1'b0;
		end else if (clk_en) begin
			if (rx_store && !rx_stop_bit) begin
				framing_error_flag_ff <= 1'b1;
			end else if (clr_framing) begin
				framing_error_flag_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Enables and control, written directly
	// Control changes apply from the next frame on
	always @(posedge clock) begin
		if (sys_rst) begin
			rx_ready_irq_enable_ff <= 1'b0;
			tx_ready_irq_enable_ff <= 1'b0;
			rx_control_register_ff <= `RST_RX_CONTROL;
		end else if (clk_en) begin
			if (wr_take && wr_lane &&
				avs_address == `OFS_RX_TX_STATUS_FLAGS) begin
				rx_ready_irq_enable_ff <= wbyte[`BIT_RX_IRQ_EN];
				tx_ready_irq_enable_ff <= wbyte[`BIT_TX_IRQ_EN];
			end
			if (wr_take && wr_lane && avs_address == `OFS_RX_CONTROL) begin
				rx_control_register_ff <= wbyte;
			end
		end
	end

	// Request flags: set wins so no ready event is lost
	always @(posedge clock) begin
		if (sys_rst) begin
			rx_ready_request_ff <= 1'b0;
			tx_ready_request_ff <= 1'b0;
		end else if (clk_en) begin
			// Only a buffer zero arrival raises the primary request
			if (hit[0]) begin
				rx_ready_request_ff <= 1'b1;
			end else if (clr_rx_req) begin
				rx_ready_request_ff <= 1'b0;
			end
			if (tx_ready_event) begin
				tx_ready_request_ff <= 1'b1;
			end else if (clr_tx_req) begin
				tx_ready_request_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Gated receive request, registered one cycle behind the flag
	// One cycle of latency traded for a flop-driven output
	always @(posedge clock) begin
		if (sys_rst) begin
			rx_ready_irq <= 1'b0;
		end else if (clk_en) begin
			rx_ready_irq <= rx_ready_request_ff & rx_ready_irq_enable_ff;
		end
	end

	// Gated transmit request, same latency as the receive side
	always @(posedge clock) begin
		if (sys_rst) begin
			tx_ready_irq <= 1'b0;
		end else if (clk_en) begin
			tx_ready_irq <= tx_ready_request_ff & tx_ready_irq_enable_ff;
		end
	end

endmodule // serial_rx_status_flags

// [rtl/serial_rx_status_flags_defs.vh]
`ifndef SERIAL_RX_STATUS_FLAGS_DEFS_VH
`define SERIAL_RX_STATUS_FLAGS_DEFS_VH

// ==========================================================
// Register byte offsets
`define OFS_RX_TX_STATUS_FLAGS 5'h00
`define OFS_RX_STATUS_BUF_ONE_TWO 5'h04
`define OFS_RX_STATUS_BUF_THREE_CNT 5'h08
`define OFS_RX_CONTROL 5'h0C
`define OFS_RX_BUFFER_ZERO 5'h10
`define OFS_RX_BUFFER_ONE 5'h14
`define OFS_RX_BUFFER_TWO 5'h18
`define OFS_RX_BUFFER_THREE 5'h1C

// ==========================================================
// Primary status field positions
`define BIT_FRAMING_ERR 0
`define BIT_OVERRUN_ZERO 1
`define BIT_PARITY_ZERO 2
`define BIT_ADDR_ERR_ZERO 3
`define BIT_RX_IRQ_EN 4
`define BIT_RX_REQ 5
`define BIT_TX_IRQ_EN 6
`define BIT_TX_REQ 7

// ==========================================================
// Buffer one/two and buffer three status field positions
`define BIT_OVERRUN_ONE 1
`define BIT_PARITY_ONE 2
`define BIT_ADDR_ERR_ONE 3
`define BIT_OVERRUN_TWO 5
`define BIT_PARITY_TWO 6
`define BIT_ADDR_ERR_TWO 7
`define BIT_OVERRUN_THREE 1
`define BIT_PARITY_THREE 2
`define BIT_ADDR_ERR_THREE 3
`define BIT_INDEX_LOW 4
`define BIT_INDEX_HIGH 5

// ==========================================================
// Control field positions
`define BIT_CTL_MP_MODE 0
`define BIT_CTL_EXPECT_ADDR 2
`define BIT_CTL_FOUR_STAGE 3
`define BIT_CTL_PARITY_EN 5
`define BIT_CTL_PARITY_EVEN 6

// ==========================================================
// Reset values and fixed read values
`define RST_RX_TX_STATUS_FLAGS 8'h00
`define RST_RX_STATUS_BUF_ONE_TWO 8'h11
`define RST_RX_STATUS_BUF_THREE_CNT 8'hC1
`define RST_RX_CONTROL 8'h00
`define ONES_BUF_ONE_TWO 8'h11
`define ONES_BUF_THREE_CNT 8'hC1

`endif

// [test/serial_rx_status_flags_properties.sv]
`timescale 1ns/10ps
// ==========================================================
// Bus handshake and request-output properties
module serial_rx_status_flags_properties (
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire rx_done,
	input wire rx_ready_irq,
	input wire tx_ready_irq
);
	// Answer cycle of a read; flags and gates are stable across it
	wire ans_rd = !avs_waitrequest && avs_read;
	wire rd0 = ans_rd && avs_address == 5'h00;
	wire req = avs_read || avs_write;
	default clocking dc @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// Handshake
	wait_answer_a: assert property (clk_en && req && avs_waitrequest
		|=> !avs_waitrequest) else $error("request not answered");
	wait_once_a: assert property (clk_en && !avs_waitrequest
		|=> avs_waitrequest) else $error("answer held too long");
	wait_idle_a: assert property (clk_en && !req |=> avs_waitrequest)
		else $error("answer without request");
	upper_zero_a: assert property (!avs_waitrequest
		|-> avs_readdata[31:8] == 24'h000000) else $error("upper bits set");
	// ==========================================================
	// Request outputs follow flag and gate
	rx_gate_on_a: assert property (rd0 && avs_readdata[5:4] == 2'b11
		|=> rx_ready_irq) else $error("receive request missing");
	rx_gate_off_a: assert property (rd0 && !avs_readdata[4]
		|=> !rx_ready_irq) else $error("receive request not gated");
	tx_gate_on_a: assert property (rd0 && avs_readdata[7:6] == 2'b11
		|=> tx_ready_irq) else $error("transmit request missing");
	tx_gate_off_a: assert property (rd0 && !avs_readdata[6]
		|=> !tx_ready_irq) else $error("transmit request not gated");
	// ==========================================================
	// Fixed read bits and reset state
	fixed_ones_a: assert property (ans_rd && avs_address == 5'h08
		|-> avs_readdata[7:6] == 2'b11 && avs_readdata[0])
		else $error("unimplemented bits not one");
	reset_quiet_a: assert property ($fell(sys_rst)
		|-> avs_waitrequest && !rx_ready_irq && !tx_ready_irq)
		else $error("outputs active after reset");
	cover property (rd0 && avs_readdata[1]);
	cover property (rx_done && clk_en);
	cover property (tx_ready_irq && rx_ready_irq);
endmodule // serial_rx_status_flags_properties

// [test/serial_rx_frame_source.sv]
`timescale 1ns/10ps
// ==========================================================
// Remote transmitter: one-cycle frame and ready pulses
module serial_rx_frame_source (
	input wire logic clock,
	output logic rx_done,
	output logic [7:0] rx_data,
	output logic rx_parity_bit,
	output logic rx_stop_bit,
	output logic address_marker_bit,
	output logic tx_ready_event
);
	// Quiet at time zero
	initial begin
		rx_done = 1'b0;
		tx_ready_event = 1'b0;
		{rx_data, rx_parity_bit, rx_stop_bit, address_marker_bit} = 11'h000;
	end
	// Lines after a frame show the inverse, so stale data cannot match
	task automatic send(input logic [7:0] d, input logic p, input logic s,
		input logic m);
		@(posedge clock);
		rx_done <= 1'b1;
		{rx_data, rx_parity_bit, rx_stop_bit, address_marker_bit} <= {d, p, s, m};
		@(posedge clock);
		rx_done <= 1'b0;
		{rx_data, rx_parity_bit, rx_stop_bit, address_marker_bit} <= ~{d, p, s, m};
	endtask
	// Transmitter ready pulse
	task automatic tx_pulse();
		@(posedge clock);
		tx_ready_event <= 1'b1;
		@(posedge clock);
		tx_ready_event <= 1'b0;
	endtask
endmodule // serial_rx_frame_source

// [test/serial_rx_status_flags_test.sv]
`timescale 1ns/10ps
// ==========================================================
// Top bench
module serial_rx_status_flags_test;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	wire [31:0] avs_readdata;
	wire [7:0] rx_data;
	wire avs_waitrequest, rx_done, rx_parity_bit, rx_stop_bit;
	wire address_marker_bit, tx_ready_event, rx_ready_irq, tx_ready_irq;
	int err_total = 0;
	int n_checks = 0;
	int k;
	logic [7:0] dat [4] = '{8'h10, 8'h21, 8'h42, 8'h84};
	logic [7:0] idx [4] = '{8'hD1, 8'hE1, 8'hF1, 8'hCD};
	logic [3:0] par = 4'b1011;
	logic [3:0] mk = 4'b1100;
	// 50 MHz clock
	always #10 clock = ~clock;
	serial_rx_status_flags serial_rx_status_flags_inst (.clock, .sys_rst,
		.clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_done,
		.rx_data, .rx_parity_bit, .rx_stop_bit, .address_marker_bit,
		.tx_ready_event, .rx_ready_irq, .tx_ready_irq);
	serial_rx_frame_source serial_rx_frame_source_inst (.clock, .rx_done,
		.rx_data, .rx_parity_bit, .rx_stop_bit, .address_marker_bit,
		.tx_ready_event);
	// ==========================================================
	// Tasks
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask
	// Request held until waitrequest is sampled low, bounded
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 20);
		if (avs_waitrequest !== 1'b0) begin
			err_total++;
			end_sim;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		acc(1'b0, a, 8'h00, q);
		chk(q[7:0], e);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rd(5'h00, 8'h00);
		rd(5'h04, 8'h11);
		rd(5'h08, 8'hC1);
		wr(5'h0C, 8'h60);
		serial_rx_frame_source_inst.send(8'h01, 1'b0, 1'b0, 1'b0);
		rd(5'h00, 8'h25);
		serial_rx_frame_source_inst.send(8'h03, 1'b0, 1'b1, 1'b0);
		rd(5'h00, 8'h27);
		rd(5'h10, 8'h03);
		wr(5'h00, 8'h50);
		rd(5'h00, 8'h50);
		serial_rx_frame_source_inst.send(8'h00, 1'b0, 1'b1, 1'b0);
		rd(5'h00, 8'h70);
		chk({7'h00, rx_ready_irq}, 8'h01);
		serial_rx_frame_source_inst.tx_pulse();
		repeat (2) @(posedge clock);
		chk({7'h00, tx_ready_irq}, 8'h01);
		rd(5'h00, 8'hF0);
		wr(5'h00, 8'hFF);
		rd(5'h00, 8'hF0);
		wr(5'h00, 8'hA0);
		rd(5'h00, 8'hA0);
		chk({6'h00, rx_ready_irq, tx_ready_irq}, 8'h00);
		// Multiprocessor: marker while data expected, then ignored frame
		wr(5'h00, 8'h00);
		wr(5'h0C, 8'h01);
		rd(5'h10, 8'h00);
		serial_rx_frame_source_inst.send(8'h55, 1'b0, 1'b1, 1'b1);
		rd(5'h00, 8'h28);
		wr(5'h0C, 8'h05);
		serial_rx_frame_source_inst.send(8'hAA, 1'b0, 1'b1, 1'b0);
		rd(5'h10, 8'h55);
		rd(5'h00, 8'h28);
		// Four-stage ring, errors per buffer, then overruns
		wr(5'h00, 8'h00);
		wr(5'h0C, 8'h69);
		for (k = 0; k < 4; k++) begin
			serial_rx_frame_source_inst.send(dat[k], par[k], 1'b1, mk[k]);
			rd(5'h08, idx[k]);
		end
		rd(5'h04, 8'h95);
		rd(5'h00, 8'h20);
		for (k = 0; k < 4; k++)
			serial_rx_frame_source_inst.send(dat[k], par[k], k != 2, mk[k]);
		rd(5'h00, 8'h23);
		rd(5'h04, 8'hB7);
		rd(5'h08, 8'hCF);
		for (k = 0; k < 4; k++)
			rd(5'h10 + 5'(4 * k), dat[k]);
		wr(5'h08, 8'h30);
		rd(5'h08, 8'hC1);
		// Enable low: a bad frame must leave index and flags alone
		clk_en <= 1'b0;
		serial_rx_frame_source_inst.send(8'h00, 1'b1, 1'b0, 1'b1);
		clk_en <= 1'b1;
		rd(5'h08, 8'hC1);
		rd(5'h00, 8'h23);
		end_sim;
	end
endmodule // serial_rx_status_flags_test

bind serial_rx_status_flags serial_rx_status_flags_properties props_inst (
	.clock, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .rx_done, .rx_ready_irq, .tx_ready_irq);
